// ===== verilog/djkff_regs.vh
// constants for the dual jk flip-flop block
// assumes inclusion by bare name from the design file
// Functional notes
// [RULE_01] two independent jk flops, own preset, clear
// [RULE_02] j and k sampled on rising clock only
// [RULE_03] preset alone forces true 1, complement 0
// [RULE_04] clear alone forces true 0, complement 1
// [RULE_05] preset and clear together drive both 1
// [RULE_06] j0 k0 edge holds state
// [RULE_07] j1 k0 edge sets true output
// [RULE_08] j0 k1 edge clears true output
// [RULE_09] j1 k1 edge toggles state
`ifndef DJKFF_REGS_VH
`define DJKFF_REGS_VH
`define DJKFF_NUM_FLOPS 2
`define DJKFF_STATE_RST 1'h0
`define DJKFF_SYNC_STAGES 2
`endif

// ===== verilog/djkff_top.v
// dual jk flip-flop with per-flop clock, preset and clear
// assumes all pins asynchronous to core_clk_in; all but arst_n_in sampled by two-flop synchronisers
`timescale 1ns/1ps
`include "djkff_regs.vh"

module djkff_top (
  input  wire       core_clk_in,      // system clock, 100 MHz
  input  wire       arst_n_in,        // async reset, active low
  input  wire [1:0] jk_clk_in,        // per-flop clock pins
  input  wire [1:0] j_in,             // per-flop j inputs
  input  wire [1:0] k_in,             // per-flop k inputs
  input  wire [1:0] async_preset_in,  // per-flop preset, active high
  input  wire [1:0] async_clear_in,   // per-flop clear, active high
  output reg  [1:0] q_out,            // true outputs
  output reg  [1:0] q_n_out           // complement outputs
);

  // synchroniser stages: stage a only feeds stage b
  reg [1:0] clk_a_r, clk_b_r, clk_d_r;
  reg [1:0] j_a_r, j_b_r, k_a_r, k_b_r;
  reg [1:0] pre_a_r, pre_b_r, clr_a_r, clr_b_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] q_nxt, q_n_nxt;
  integer   i;

  // two-flop synchronisers; j/k share latency with the clock pin so setup holds
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_a_r <= 2'h0;
      clk_b_r <= 2'h0;
      clk_d_r <= 2'h0;
      j_a_r   <= 2'h0;
      j_b_r   <= 2'h0;
      k_a_r   <= 2'h0;
      k_b_r   <= 2'h0;
      pre_a_r <= 2'h0;
      pre_b_r <= 2'h0;
      clr_a_r <= 2'h0;
      clr_b_r <= 2'h0;
    end else begin
      clk_a_r <= jk_clk_in;
      clk_b_r <= clk_a_r;
      clk_d_r <= clk_b_r;
      j_a_r   <= j_in;
      j_b_r   <= j_a_r;
      k_a_r   <= k_in;
      k_b_r   <= k_a_r;
      pre_a_r <= async_preset_in;
      pre_b_r <= pre_a_r;
      clr_a_r <= async_clear_in;
      clr_b_r <= clr_a_r;
    end
  end

  // per-flop next state; each bit touches only its own inputs
  always @* begin
    state_nxt = state_r;
    q_nxt     = 2'h0;
    q_n_nxt   = 2'h0;
    for (i = 0; i < `DJKFF_NUM_FLOPS; i = i + 1) begin                // [RULE_01]
      if (pre_b_r[i] || clr_b_r[i]) begin
        state_nxt[i] = pre_b_r[i];                                     // stored value follows the force
      end else if (clk_b_r[i] && !clk_d_r[i]) begin                    // [RULE_02]
        case ({j_b_r[i], k_b_r[i]})
          2'b00:   state_nxt[i] = state_r[i];                          // [RULE_06]
          2'b10:   state_nxt[i] = 1'b1;                                // [RULE_07]
          2'b01:   state_nxt[i] = 1'b0;                                // [RULE_08]
          2'b11:   state_nxt[i] = ~state_r[i];                         // [RULE_09]
          default: state_nxt[i] = state_r[i];
        endcase
      end
      // forces override the stored value; both high drives both outputs high
      if (pre_b_r[i] && clr_b_r[i]) begin
        q_nxt[i]   = 1'b1;                                             // [RULE_05]
        q_n_nxt[i] = 1'b1;
      end else if (pre_b_r[i]) begin
        q_nxt[i]   = 1'b1;                                             // [RULE_03]
        q_n_nxt[i] = 1'b0;
      end else if (clr_b_r[i]) begin
        q_nxt[i]   = 1'b0;                                             // [RULE_04]
        q_n_nxt[i] = 1'b1;
      end else begin
        q_nxt[i]   = state_nxt[i];
        q_n_nxt[i] = ~state_nxt[i];
      end
    end
  end

  // state and registered outputs
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= {2{`DJKFF_STATE_RST}};
      q_out   <= 2'h0;
      q_n_out <= 2'h3;
    end else begin
      state_r <= state_nxt;
      q_out   <= q_nxt;
      q_n_out <= q_n_nxt;
    end
  end

endmodule // djkff_top

// ===== tb/djkff_properties.sv
// checker for the dual jk block: clocked behaviour on flop 0, forces on both flops
// assumes bind to djkff_top, 3 cycles pin to output
`timescale 1ns/1ps
module djkff_properties (input logic core_clk_in, arst_n_in,
  input logic [1:0] jk_clk_in, j_in, k_in, async_preset_in, async_clear_in, q_out, q_n_out);
  wire p = async_preset_in[0], c = async_clear_in[0], q = q_out[0], qn = q_n_out[0];
  // flop 1 carries the force scenarios of the bench, so its forces are watched too
  wire p1 = async_preset_in[1], c1 = async_clear_in[1], q1 = q_out[1], qn1 = q_n_out[1];
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // forces quiet long enough that only the clock rise moves the flop
  sequence s_rise; (!p && !c)[*3] ##0 $rose(jk_clk_in[0]); endsequence
  chk_preset_only: assert property ((p && !c)[*3] |=> q && !qn) else $error("preset");
  chk_clear_only: assert property ((c && !p)[*3] |=> !q && qn) else $error("clear");
  chk_both_forced: assert property ((p && c)[*3] |=> q && qn) else $error("both");
  chk_hold_edge: assert property (s_rise ##0 (!j_in[0] && !k_in[0]) |-> ##3 $stable(q)) else $error("hold");
  chk_set_edge: assert property (s_rise ##0 (j_in[0] && !k_in[0]) |-> ##3 q && !qn) else $error("set");
  chk_clr_edge: assert property (s_rise ##0 (!j_in[0] && k_in[0]) |-> ##3 !q && qn) else $error("clr");
  chk_toggle_edge: assert property (s_rise ##0 (j_in[0] && k_in[0]) |-> ##3 q != $past(q) && qn == !q) else $error("tog");
  chk_no_edge: assert property ((!p && !c && !$rose(jk_clk_in[0]))[*4] |=> $stable(q)) else $error("stray");
  chk_preset_one: assert property ((p1 && !c1)[*3] |=> q1 && !qn1) else $error("preset flop 1");
  chk_clear_one: assert property ((c1 && !p1)[*3] |=> !q1 && qn1) else $error("clear flop 1");
  chk_both_one: assert property ((p1 && c1)[*3] |=> q1 && qn1) else $error("both flop 1");
endmodule // djkff_properties

// ===== tb/djkff_top_tb.sv
// bench for the dual jk block, inputs driven at falling edge
// assumes djkff_top with its 3-cycle pin-to-output latency
`timescale 1ns/1ps
`define CHK(n,e,g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %b got %b", n, e, g); end end
module djkff_top_tb;
  logic core_clk_in = 0, arst_n_in = 0;
  logic [1:0] jk_clk_in = 0, j_in = 0, k_in = 0, async_preset_in = 0, async_clear_in = 0;
  wire [1:0] q_out, q_n_out;
  int fail_count = 0, compares = 0, cyc = 0;
  djkff_top i_dut (.*);
  always #5 core_clk_in = ~core_clk_in;
  // tests need about 66 cycles
  always @(posedge core_clk_in) if (++cyc > 999) begin fail_count++; results; end
  task w(int n); repeat (n) @(negedge core_clk_in); endtask
  task ck(int i, bit e); `CHK("q", e, q_out[i]) `CHK("qn", !e, q_n_out[i]) endtask
  // clock high and low 3 cycles each, beyond the 2 the synchroniser needs
  task ej(int i, bit a, b); j_in[i] = a; k_in[i] = b; w(1); jk_clk_in[i] = 1; w(3); jk_clk_in[i] = 0; w(3); endtask
  task fc(bit p, c); async_preset_in[1] = p; async_clear_in[1] = c; w(5); endtask
  task t_jk; ej(0, 1, 0); ck(0, 1);
    ej(0, 0, 0); ck(0, 1);
    ej(0, 1, 1); ck(0, 0);
    ej(0, 1, 1); ck(0, 1);
    ej(0, 0, 1); ck(0, 0);
    `CHK("q1", 1'b0, q_out[1])
  endtask
  task t_force; fc(1, 0); ck(1, 1);
    fc(1, 1); `CHK("both", 2'h3, {q_out[1], q_n_out[1]})
    fc(0, 1); ck(1, 0);
    ej(1, 1, 0); ck(1, 0);
    fc(0, 0); `CHK("q0", 1'b0, q_out[0])
    ck(1, 0);
  endtask
  task results; $display("fail_count %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS"); else $display("DONE - FAIL");
    $finish; endtask
  initial begin w(2); arst_n_in = 1; w(2); t_jk; t_force; results; end
endmodule // djkff_top_tb
bind djkff_top djkff_properties i_chk (.*);
